//--- core/manual_trigger_key_seq_pkg.sv
// Package for the trigger layer sequencer: map, fields, timing, types
package manual_trigger_key_seq_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] SRC_OFF      = 8'h04;
  localparam logic [7:0] ARMCNT_OFF   = 8'h08;
  localparam logic [7:0] SCANCNT_OFF  = 8'h0C;
  localparam logic [7:0] MEASCNT_OFF  = 8'h10;
  localparam logic [7:0] TIMER_OFF    = 8'h14;
  localparam logic [7:0] STATUS_OFF   = 8'h18;
  localparam logic [7:0] IRQSTAT_OFF  = 8'h1C;
  localparam logic [7:0] IRQMASK_OFF  = 8'h20;

  // ==========================================================================
  // CTRL fields (write-one command bits, bits 3 and 4 are levels)
  localparam int CTRL_INIT_BIT  = 0;
  localparam int CTRL_SIGN_BIT  = 1;
  localparam int CTRL_IMM_BIT   = 2;
  localparam int CTRL_CONT_BIT  = 3;
  localparam int CTRL_SCAN_BIT  = 4;
  localparam int CTRL_ABORT_BIT = 5;

  // SRC fields: arm [2:0], scan [6:4], measure [10:8]
  localparam int SRC_ARM_LSB  = 0;
  localparam int SRC_SCAN_LSB = 4;
  localparam int SRC_MEAS_LSB = 8;

  // Interrupt bits
  localparam int IRQ_IGNORED_BIT = 0;
  localparam int IRQ_READING_BIT = 1;
  localparam int IRQ_DONE_BIT    = 2;
  localparam int IRQ_WIDTH       = 3;

  // ==========================================================================
  // Counts: zero means infinite
  localparam int          CNT_W        = 17;
  localparam logic [16:0] CNT_MAX      = 17'h1869F;
  localparam logic [16:0] CNT_INFINITE = 17'h00000;
  localparam logic [16:0] ARM_CNT_RST  = 17'h00001;
  localparam logic [16:0] SCAN_CNT_RST = 17'h00000;
  localparam logic [16:0] MEAS_CNT_RST = 17'h00000;

  // Timer interval in ms, 1 to 999,999,999
  localparam int          TMR_W      = 30;
  localparam logic [29:0] TMR_MIN_MS = 30'h00000001;
  localparam logic [29:0] TMR_MAX_MS = 30'h3B9AC9FF;
  localparam logic [29:0] TMR_RST_MS = 30'h00000001;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Event sources
  typedef enum logic [2:0] {
    SRC_IMM  = 3'h0,
    SRC_EXT  = 3'h1,
    SRC_MAN  = 3'h2,
    SRC_BUS  = 3'h3,
    SRC_LINK = 3'h4,
    SRC_TMR  = 3'h5,
    SRC_HOLD = 3'h6
  } src_e;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ARM   = 4'h1,
    ST_SCAN  = 4'h2,
    ST_MEAS  = 4'h3,
    ST_READ  = 4'h4,
    ST_OPEN  = 4'h5,
    ST_CONF  = 4'h6,
    ST_CLOSE = 4'h7,
    ST_NEXT  = 4'h8
  } state_e;

  // Device action strobes toward the measuring front end
  typedef struct packed {
    logic takeReading;
    logic openChannel;
    logic configNext;
    logic closeChannel;
  } action_s;

  // Raw trigger inputs from outside the clock domain
  typedef struct packed {
    logic extTrigger;
    logic manualTriggerKey;
    logic busTrigger;
    logic linkTrigger;
  } manual_trigger_key_in_s;

endpackage : manual_trigger_key_seq_pkg

//--- core/trigger_layer_sequencer.sv
// Trigger layer sequencer: idle, arm, scan and measure layers with AXI4-Lite
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none

module trigger_layer_sequencer
  import manual_trigger_key_seq_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  // Clock, reset, enable
  input  wire logic          core_clk,
  input  wire logic          srst,
  input  wire logic          clkEn,
  // AXI4-Lite slave
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Trigger pins
  input  wire manual_trigger_key_in_s      trigIn,
  // Indicators and actions
  output logic               armedInd,
  output logic               triggerIgnored,
  output action_s            action,
  output logic               irq
);

  initial
  begin
    if (TICK_CYC < 1)
      $error("TICK_CYC must be at least one");
  end

  // ==========================================================================
  // Pin synchronisers and edge detect
  manual_trigger_key_in_s syncA_ff;
  manual_trigger_key_in_s syncB_ff;
  manual_trigger_key_in_s prevB_ff;
  manual_trigger_key_in_s trigPulse;

  // Two stages; only the second stage feeds logic
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      syncA_ff <= '0;
      syncB_ff <= '0;
      prevB_ff <= '0;
    end
    else if (clkEn)
    begin
      syncA_ff <= trigIn;
      syncB_ff <= syncA_ff;
      prevB_ff <= syncB_ff;
    end
  end
  assign trigPulse = syncB_ff & ~prevB_ff;

  // ==========================================================================
  // Registers
  src_e        armSrc_ff, scanSrc_ff, measSrc_ff;
  logic        contInit_ff;
  logic        scanEn_ff;
  logic [16:0] armCnt_ff, scanCnt_ff, measCnt_ff;
  logic [29:0] tmrMs_ff;
  logic [2:0]  irqStat_ff, irqMask_ff;
  logic        initCmd, signCmd, immCmd, abortCmd;

  // Write channel: take address and data in either order
  logic [7:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        awHave_ff, wHave_ff;
  logic        doWrite;

  // Readies drop while frozen so that no beat is lost
  assign s_axi_awready = clkEn & ~awHave_ff & ~s_axi_bvalid;
  assign s_axi_wready  = clkEn & ~wHave_ff & ~s_axi_bvalid;
  assign doWrite       = awHave_ff & wHave_ff & ~s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      awHave_ff    <= 1'b0;
      wHave_ff     <= 1'b0;
      awAddr_ff    <= 8'h00;
      wData_ff     <= 32'h00000000;
      wStrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else if (clkEn)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHave_ff    <= 1'b0;
        wHave_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Full-word writes only; partial strobes on a field are ignored
  logic wrFull;
  assign wrFull = doWrite && (wStrb_ff == 4'hF);

  assign initCmd  = wrFull && awAddr_ff == CTRL_OFF
                    && wData_ff[CTRL_INIT_BIT];
  assign signCmd  = wrFull && awAddr_ff == CTRL_OFF
                    && wData_ff[CTRL_SIGN_BIT];
  assign immCmd   = wrFull && awAddr_ff == CTRL_OFF
                    && wData_ff[CTRL_IMM_BIT];
  assign abortCmd = wrFull && awAddr_ff == CTRL_OFF
                    && wData_ff[CTRL_ABORT_BIT];

  // Configuration registers; out-of-range counts are clamped
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      armSrc_ff   <= SRC_IMM;
      scanSrc_ff  <= SRC_IMM;
      measSrc_ff  <= SRC_IMM;
      contInit_ff <= 1'b0;
      scanEn_ff   <= 1'b0;
      armCnt_ff   <= ARM_CNT_RST;
      scanCnt_ff  <= SCAN_CNT_RST;
      measCnt_ff  <= MEAS_CNT_RST;
      tmrMs_ff    <= TMR_RST_MS;
      irqMask_ff  <= '0;
    end
    else if (clkEn && wrFull)
    begin
      if (awAddr_ff == CTRL_OFF)
      begin
        contInit_ff <= wData_ff[CTRL_CONT_BIT];
        scanEn_ff   <= wData_ff[CTRL_SCAN_BIT];
      end
      else if (awAddr_ff == SRC_OFF)
      begin
        armSrc_ff  <= src_e'(wData_ff[SRC_ARM_LSB +: 3]);
        scanSrc_ff <= src_e'(wData_ff[SRC_SCAN_LSB +: 3]);
        measSrc_ff <= src_e'(wData_ff[SRC_MEAS_LSB +: 3]);
      end
      else if (awAddr_ff == ARMCNT_OFF)
        armCnt_ff <= (wData_ff[16:0] > CNT_MAX) ? CNT_MAX
                     : wData_ff[16:0];
      else if (awAddr_ff == SCANCNT_OFF)
        scanCnt_ff <= (wData_ff[16:0] > CNT_MAX) ? CNT_MAX
                      : wData_ff[16:0];
      else if (awAddr_ff == MEASCNT_OFF)
        measCnt_ff <= (wData_ff[16:0] > CNT_MAX) ? CNT_MAX
                      : wData_ff[16:0];
      else if (awAddr_ff == TIMER_OFF)
        tmrMs_ff <= (wData_ff[29:0] < TMR_MIN_MS) ? TMR_MIN_MS
                    : (wData_ff[29:0] > TMR_MAX_MS) ? TMR_MAX_MS
                    : wData_ff[29:0];
      else if (awAddr_ff == IRQMASK_OFF)
        irqMask_ff <= wData_ff[2:0];
    end
  end

  // ==========================================================================
  // Sequencer
  state_e      state_ff;
  logic [16:0] armDone_ff, scanDone_ff, measDone_ff;
  logic        scanFirst_ff, measFirst_ff;
  logic        tmrExpired_ff;

  // Event match for a layer's selected source
  function automatic logic evMatch(input src_e s, input manual_trigger_key_in_s p,
                                   input logic tmr, input logic first);
    evMatch = 1'b0;
    case (s)
      SRC_IMM:  evMatch = 1'b1;
      SRC_EXT:  evMatch = p.extTrigger;
      SRC_MAN:  evMatch = p.manualTriggerKey;
      SRC_BUS:  evMatch = p.busTrigger;
      SRC_LINK: evMatch = p.linkTrigger;
      SRC_TMR:  evMatch = first | tmr;
      default:  evMatch = 1'b0;
    endcase
  endfunction : evMatch

  logic armEv, scanEv, measEv;
  logic lastMeas, lastScan, lastArm;
  logic startCmd;

  // Bypass commands satisfy the arm layer even under hold
  assign armEv  = evMatch(armSrc_ff, trigPulse, 1'b0, 1'b0)
                  | signCmd | immCmd;
  assign scanEv = evMatch(scanSrc_ff, trigPulse, tmrExpired_ff,
                          scanFirst_ff);
  assign measEv = evMatch(measSrc_ff, trigPulse, tmrExpired_ff,
                          measFirst_ff);
  assign lastMeas = measCnt_ff != CNT_INFINITE
                    && measDone_ff + 17'h00001 >= measCnt_ff;
  assign lastScan = scanCnt_ff != CNT_INFINITE
                    && scanDone_ff + 17'h00001 >= scanCnt_ff;
  assign lastArm  = armCnt_ff != CNT_INFINITE
                    && armDone_ff + 17'h00001 >= armCnt_ff;
  assign startCmd = initCmd | contInit_ff
                    | trigPulse.manualTriggerKey;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_ff     <= ST_IDLE;
      armDone_ff   <= '0;
      scanDone_ff  <= '0;
      measDone_ff  <= '0;
      scanFirst_ff <= 1'b1;
      measFirst_ff <= 1'b1;
    end
    else if (clkEn)
    begin
      if (abortCmd)
        state_ff <= ST_IDLE;
      else
      begin
        case (state_ff)
          ST_IDLE:
            if (startCmd)
            begin
              state_ff   <= ST_ARM;
              armDone_ff <= '0;
            end
          ST_ARM:
            if (armEv)
            begin
              state_ff     <= ST_SCAN;
              scanDone_ff  <= '0;
              scanFirst_ff <= 1'b1;
            end
          ST_SCAN:
            if (scanEv)
            begin
              state_ff     <= ST_MEAS;
              scanFirst_ff <= 1'b0;
              measDone_ff  <= '0;
              measFirst_ff <= 1'b1;
            end
          ST_MEAS:
            if (measEv)
            begin
              state_ff     <= ST_READ;
              measFirst_ff <= 1'b0;
            end
          ST_READ:
            state_ff <= scanEn_ff ? ST_OPEN : ST_NEXT;
          ST_OPEN:
            state_ff <= ST_CONF;
          ST_CONF:
            state_ff <= ST_CLOSE;
          ST_CLOSE:
            state_ff <= ST_NEXT;
          ST_NEXT:
          begin
            measDone_ff <= measDone_ff + 17'h00001;
            if (!lastMeas)
              state_ff <= ST_MEAS;
            else if (!lastScan)
            begin
              state_ff    <= ST_SCAN;
              scanDone_ff <= scanDone_ff + 17'h00001;
            end
            else if (!lastArm)
            begin
              state_ff   <= ST_ARM;
              armDone_ff <= armDone_ff + 17'h00001;
            end
            else
              state_ff <= ST_IDLE;
          end
          default:
            state_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // Interval timer: ms tick prescaler plus ms counter, restarts per pass
  logic [31:0] preCnt_ff;
  logic [29:0] msCnt_ff;
  logic        tmrRestart;

  assign tmrRestart = (state_ff == ST_SCAN && scanEv)
                      || (state_ff == ST_MEAS && measEv);

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      preCnt_ff     <= '0;
      msCnt_ff      <= '0;
      tmrExpired_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (tmrRestart || state_ff == ST_IDLE)
      begin
        preCnt_ff     <= '0;
        msCnt_ff      <= '0;
        tmrExpired_ff <= 1'b0;
      end
      else if (!tmrExpired_ff)
      begin
        if (preCnt_ff == 32'(TICK_CYC - 1))
        begin
          preCnt_ff <= '0;
          msCnt_ff  <= msCnt_ff + 30'h00000001;
          if (msCnt_ff + 30'h00000001 >= tmrMs_ff)
            tmrExpired_ff <= 1'b1;
        end
        else
          preCnt_ff <= preCnt_ff + 32'h00000001;
      end
    end
  end

  // ==========================================================================
  // Outputs, ignored triggers and interrupts
  logic ignoredEv;
  logic [2:0] irqSet;

  // Ext or key trigger under an immediate layer is dropped;
  // the device action steps still belong to the measure layer
  always_comb
  begin
    ignoredEv = 1'b0;
    if (trigPulse.extTrigger
        || (trigPulse.manualTriggerKey && state_ff != ST_IDLE))
    begin
      if ((state_ff == ST_ARM && armSrc_ff == SRC_IMM)
          || (state_ff == ST_SCAN && scanSrc_ff == SRC_IMM)
          || (state_ff != ST_IDLE && state_ff != ST_ARM
              && state_ff != ST_SCAN && measSrc_ff == SRC_IMM))
        ignoredEv = 1'b1;
    end
  end

  assign irqSet[IRQ_IGNORED_BIT] = ignoredEv;
  assign irqSet[IRQ_READING_BIT] = state_ff == ST_READ;
  assign irqSet[IRQ_DONE_BIT]    = state_ff == ST_NEXT && lastMeas
                                   && lastScan && lastArm;

  // Set beats write-one-to-clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (srst)
      irqStat_ff <= '0;
    else if (clkEn)
    begin
      if (wrFull && awAddr_ff == IRQSTAT_OFF)
        irqStat_ff <= (irqStat_ff & ~wData_ff[2:0]) | irqSet;
      else
        irqStat_ff <= irqStat_ff | irqSet;
    end
  end
  assign irq = |(irqStat_ff & irqMask_ff);

  // Registered indicator and action strobes
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      armedInd       <= 1'b0;
      triggerIgnored <= 1'b0;
      action         <= '0;
    end
    else if (clkEn)
    begin
      armedInd            <= state_ff != ST_IDLE;
      triggerIgnored      <= ignoredEv;
      action.takeReading  <= state_ff == ST_READ;
      action.openChannel  <= state_ff == ST_OPEN;
      action.configNext   <= state_ff == ST_CONF;
      action.closeChannel <= state_ff == ST_CLOSE;
    end
  end

  // ==========================================================================
  // Read channel
  logic [31:0] rdMux;

  always_comb
  begin
    rdMux = 32'h00000000;
    if (s_axi_araddr == CTRL_OFF)
      rdMux = {26'h0, 1'b0, scanEn_ff, contInit_ff, 3'h0};
    else if (s_axi_araddr == SRC_OFF)
      rdMux = {21'h0, measSrc_ff, 1'b0, scanSrc_ff, 1'b0, armSrc_ff};
    else if (s_axi_araddr == ARMCNT_OFF)
      rdMux = {15'h0, armCnt_ff};
    else if (s_axi_araddr == SCANCNT_OFF)
      rdMux = {15'h0, scanCnt_ff};
    else if (s_axi_araddr == MEASCNT_OFF)
      rdMux = {15'h0, measCnt_ff};
    else if (s_axi_araddr == TIMER_OFF)
      rdMux = {2'h0, tmrMs_ff};
    else if (s_axi_araddr == STATUS_OFF)
      rdMux = {measDone_ff[15:0], 11'h0, armedInd, state_ff};
    else if (s_axi_araddr == IRQSTAT_OFF)
      rdMux = {29'h0, irqStat_ff};
    else if (s_axi_araddr == IRQMASK_OFF)
      rdMux = {29'h0, irqMask_ff};
  end

  assign s_axi_arready = clkEn & ~s_axi_rvalid;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end
    else if (clkEn)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= 2'h0;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : trigger_layer_sequencer

`default_nettype wire

//--- sim/manual_trigger_key_seq_asserts.sv
// Checker: port-level assertions for the trigger layer sequencer
`default_nettype none
module manual_trigger_key_seq_asserts
  import manual_trigger_key_seq_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       srst,
  // Bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  // Pins and actions
  input wire manual_trigger_key_in_s   trigIn,
  input wire logic       armedInd,
  input wire logic       triggerIgnored,
  input wire action_s    action
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // ======
  // Sequencer behaviour
  AST_IDLE_DARK: assert property ($fell(srst) |-> !armedInd)
    else $error("armed indicator high out of reset");
  AST_KEY_ARMS: assert property (
    $rose(trigIn.manualTriggerKey) && !armedInd |-> ##[2:8] armedInd)
    else $error("key press did not arm");
  AST_READ_PULSE: assert property (
    action.takeReading |=> !action.takeReading)
    else $error("reading strobe longer than one cycle");
  AST_OPEN_ORDER: assert property (
    action.openChannel |-> $past(action.takeReading))
    else $error("open not right after reading");
  AST_CONF_ORDER: assert property (
    action.configNext |-> $past(action.openChannel))
    else $error("configure not right after open");
  AST_CLOSE_ORDER: assert property (
    action.closeChannel |-> $past(action.configNext))
    else $error("close not right after configure");
  // Pulses held six cycles, so depth three always sees the cause
  AST_IGN_CAUSE: assert property (
    triggerIgnored |-> $past(trigIn.extTrigger, 3)
      || $past(trigIn.manualTriggerKey, 3))
    else $error("ignored flag without a trigger");

  // ======
  // Register bus answers
  AST_RD_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_STANDS: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && s_axi_rresp == 2'h0)
    else $error("read answer dropped");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");

  // Main scenarios reached
  COV_READ: cover property (action.takeReading);
  COV_CLOSE: cover property (action.closeChannel);
  COV_IGN: cover property (triggerIgnored);
endmodule : manual_trigger_key_seq_asserts

bind trigger_layer_sequencer manual_trigger_key_seq_asserts checkInst (
  .core_clk(core_clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rresp(s_axi_rresp), .trigIn(trigIn), .armedInd(armedInd),
  .triggerIgnored(triggerIgnored), .action(action));
`default_nettype wire

//--- sim/manual_trigger_key_source_model.sv
// Model of the outside trigger sources feeding the sequencer pins
`default_nettype none
module manual_trigger_key_source_model
  import manual_trigger_key_seq_pkg::*;
(
  // Clock
  input  wire logic core_clk,
  // Trigger pins
  output manual_trigger_key_in_s  trigOut
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins rest low between events
  initial trigOut = '0;

  // One event: optional delay, six cycles high, two low for the sampler
  task automatic pulse(input int idx, input int lag);
    repeat (lag + 1) @(posedge core_clk);
    trigOut[idx] <= 1'b1;
    repeat (6) @(posedge core_clk);
    trigOut[idx] <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : pulse
endmodule : manual_trigger_key_source_model
`default_nettype wire

//--- sim/trigger_layer_sequencer_tb.sv
// Self-checking bench for the trigger layer sequencer
`default_nettype none
module trigger_layer_sequencer_tb
  import manual_trigger_key_seq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TCYC = 10; // Shortened millisecond keeps runs brief

  logic core_clk, srst, clkEn, awvalid, wvalid, bvalid, bready;
  logic awready, wready, arvalid, arready, rvalid, rready, armedInd;
  logic triggerIgnored, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  manual_trigger_key_in_s trigIn;
  action_s action;
  int mismatches = 0, compares = 0;
  int readCnt = 0, closeCnt = 0, ignCnt = 0, cyc = 0, lastRd = 0, gap = 0;

  // ======
  // Design and trigger sources
  trigger_layer_sequencer #(.TICK_CYC(TCYC)) trigger_layer_sequencer_inst (
    .core_clk(core_clk), .srst(srst), .clkEn(clkEn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .trigIn(trigIn), .armedInd(armedInd),
    .triggerIgnored(triggerIgnored), .action(action), .irq(irq));
  manual_trigger_key_source_model src (.core_clk(core_clk), .trigOut(trigIn));

  // Clock
  always #5 core_clk = ~core_clk;

  // Count strobes; reading gap is in cycles
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (action.takeReading === 1'b1)
    begin
      readCnt <= readCnt + 1;
      gap <= cyc - lastRd;
      lastRd <= cyc;
    end
    if (action.closeChannel === 1'b1)
      closeCnt <= closeCnt + 1;
    if (triggerIgnored === 1'b1)
      ignCnt <= ignCnt + 1;
  end

  // ======
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge core_clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      aw = aw || awready === 1'b1;
      w = w || wready === 1'b1;
    end
    while (bvalid !== 1'b1)
      @(posedge core_clk);
    check("write response", 32'h0, {30'h0, bresp});
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge core_clk);
    d = rdata;
    rready <= 1'b0;
  endtask : rd

  task automatic wait_idle();
    repeat (3) @(posedge core_clk);
    while (armedInd !== 1'b0)
      @(posedge core_clk);
  endtask : wait_idle

  task automatic run(input logic [31:0] nA, nS, nM, input int exp);
    int base;
    wr(ARMCNT_OFF, nA);
    wr(SCANCNT_OFF, nS);
    wr(MEASCNT_OFF, nM);
    base = readCnt;
    wr(CTRL_OFF, 32'h1);
    wait_idle();
    check("readings", base + exp, readCnt);
  endtask : run

  // ======
  // Scenarios
  task automatic t_reset_vals();
    logic [7:0] offs [10] = '{CTRL_OFF, SRC_OFF, ARMCNT_OFF, SCANCNT_OFF,
      MEASCNT_OFF, TIMER_OFF, STATUS_OFF, IRQSTAT_OFF, IRQMASK_OFF, 8'h3C};
    logic [31:0] exps [10] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h1,
      32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] v;
    foreach (offs[i])
    begin
      rd(offs[i], v);
      check("reset value", exps[i], v);
    end
    wr(ARMCNT_OFF, 32'h1FFFF);
    rd(ARMCNT_OFF, v);
    check("count clamp", 32'(CNT_MAX), v);
  endtask : t_reset_vals

  task automatic t_runs();
    wr(IRQMASK_OFF, 32'h4);
    run(32'h1, 32'h1, 32'h4, 4);
    check("done irq", 32'h1, {31'h0, irq});
    wr(IRQSTAT_OFF, 32'h4);
    check("done cleared", 32'h0, {31'h0, irq});
    run(32'h2, 32'h3, 32'h2, 12);
  endtask : t_runs

  task automatic t_sources();
    int base;
    wr(ARMCNT_OFF, 32'h1);
    wr(SCANCNT_OFF, 32'h1);
    wr(MEASCNT_OFF, 32'h1);
    for (int l = 0; l <= 8; l += 4)
      for (int s = 1; s <= 4; s++)
      begin
        wr(SRC_OFF, 32'(s) << l);
        base = readCnt;
        wr(CTRL_OFF, 32'h1);
        repeat (20) @(posedge core_clk);
        check("waiting", base, readCnt);
        src.pulse(4 - s, l);
        wait_idle();
        check("after event", base + 1, readCnt);
      end
  endtask : t_sources

  task automatic t_hold();
    int base;
    wr(SRC_OFF, 32'h6);
    for (int b = 1; b <= 2; b++)
    begin
      base = readCnt;
      wr(CTRL_OFF, 32'h1);
      repeat (20) @(posedge core_clk);
      check("hold waits", base, readCnt);
      wr(CTRL_OFF, 32'h1 << b);
      wait_idle();
      check("hold released", base + 1, readCnt);
    end
  endtask : t_hold

  task automatic t_start();
    int base;
    wr(SRC_OFF, 32'h0);
    base = readCnt;
    src.pulse(2, 1);
    wait_idle();
    check("key start", base + 1, readCnt);
    wr(CTRL_OFF, 32'h8);
    repeat (40) @(posedge core_clk);
    check("continuous", 32'h1, 32'(readCnt > base + 3));
    wr(CTRL_OFF, 32'h20);
    wait_idle();
    check("armed off", 32'h0, {31'h0, armedInd});
  endtask : t_start

  task automatic t_scan();
    int base;
    base = closeCnt;
    wr(SRC_OFF, 32'h0);
    wr(MEASCNT_OFF, 32'h2);
    wr(CTRL_OFF, 32'h11);
    wait_idle();
    check("channel steps", base + 2, closeCnt);
    wr(CTRL_OFF, 32'h0);
  endtask : t_scan

  task automatic t_timer();
    int base;
    wr(TIMER_OFF, 32'h2);
    for (int l = 4; l <= 8; l += 4)
    begin
      wr(SRC_OFF, 32'h5 << l);
      wr(SCANCNT_OFF, (l == 4) ? 32'h3 : 32'h1);
      wr(MEASCNT_OFF, (l == 8) ? 32'h3 : 32'h1);
      base = readCnt;
      wr(CTRL_OFF, 32'h1);
      repeat (8) @(posedge core_clk);
      check("first pass", base + 1, readCnt);
      wait_idle();
      check("gap", 32'h1, 32'(gap > 2 * TCYC - 2 && gap < 2 * TCYC + 3));
    end
  endtask : t_timer

  task automatic t_ignored();
    int base;
    wr(SRC_OFF, 32'h0);
    wr(MEASCNT_OFF, 32'h0);
    wr(IRQMASK_OFF, 32'h1);
    wr(IRQSTAT_OFF, 32'h7);
    wr(CTRL_OFF, 32'h1);
    for (int i = 2; i <= 3; i++)
    begin
      base = ignCnt;
      src.pulse(i, 0);
      repeat (4) @(posedge core_clk);
      check("ignored", base + 1, ignCnt);
      check("irq raised", 32'h1, {31'h0, irq});
      wr(IRQSTAT_OFF, 32'h1);
      check("irq cleared", 32'h0, {31'h0, irq});
    end
    wr(CTRL_OFF, 32'h20);
    wait_idle();
  endtask : t_ignored

  // Verdict and end of run
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // Hang guard
  initial
  begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    core_clk = 1'b0;
    srst = 1'b1;
    clkEn = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    t_reset_vals();
    t_runs();
    t_sources();
    t_start();
    t_hold();
    t_scan();
    t_timer();
    t_ignored();
    wrap_up();
  end
endmodule : trigger_layer_sequencer_tb
`default_nettype wire
